// [rtl/blank_filter.sv]
// module: qualifies a comparator level after a blanking time
`timescale 1ns/1ns
module blank_filter
  import charge_guard_pkg::*;
#(
  parameter int BLANK_CYC = 2
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // comparator level in, qualified level out
  input  wire logic level_in,
  output logic      confirmed
);

  logic [CNT_W-1:0] count;
  wire              at_end = (count == CNT_W'(BLANK_CYC - 1));

  always_ff @(posedge clk) begin
    if (!resetn || !level_in) begin
      count     <= '0;
      confirmed <= 1'b0;
    end else if (at_end) begin
      confirmed <= 1'b1;
    end else begin
      count <= count + CNT_W'(1);
    end
  end

endmodule

// [rtl/charge_guard_pkg.sv]
// package: constants and carrier types for the charge path protection block
package charge_guard_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS       = 10;
  localparam int STARTUP_DELAY_MS    = 10;
  localparam int STARTUP_DELAY_CYC   =
    (STARTUP_DELAY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OVIN_RESPONSE_US    = 1;
  localparam int OVIN_RESPONSE_CYC   =
    (OVIN_RESPONSE_US * 1000) / CLK_PERIOD_NS;
  localparam int BATT_BLANK_US       = 180;
  localparam int BATT_BLANK_CYC      =
    (BATT_BLANK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OCUR_BLANK_NS       = 2000;
  localparam int OCUR_BLANK_CYC      =
    (OCUR_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_PERIOD_NS      = 1000;
  localparam int TICK_CYC            = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int HICCUP_RETRY_US     = 1000;
  localparam int RAMP_STEP_TICKS     = 4;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int    CNT_W            = 24;
  localparam int    GATE_W           = 8;
  localparam int    EVENT_W          = 4;
  localparam logic [GATE_W-1:0]  GATE_OFF  = 8'h00;
  localparam logic [GATE_W-1:0]  GATE_FULL = 8'hff;
  localparam logic [EVENT_W-1:0] EVENT_LAST = 4'hf;
  localparam logic [EVENT_W-1:0] EVENT_RST  = 4'h0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic input_overvoltage_comparator;
    logic overcurrent_comparator;
    logic battery_overvoltage_comparator;
    logic temp_rising_limit;
    logic temp_falling_limit;
  } sense_t;

  typedef struct packed {
    logic overvoltage_trip;
    logic battery_trip;
    logic overcurrent_trip;
    logic thermal_trip;
  } trip_t;

  typedef enum logic [4:0] {
    ST_OFF     = 5'b00001,
    ST_DELAY   = 5'b00010,
    ST_RAMP    = 5'b00100,
    ST_ON      = 5'b01000,
    ST_LOCKED  = 5'b10000
  } state_t;

endpackage

// [rtl/charge_path_protection_controller.sv]
// module: sequencing and fault control for the series power switch
`timescale 1ns/1ns

// Function
// - switch off until supply valid rises
// - settle delay after supply valid, then soft-start
// - soft-start ramps switch drive in steps
// - input overvoltage removes drive within one microsecond
// - after input overvoltage, redo delay and soft-start
// - overvoltage at delay end blocks switch enable
// - battery overvoltage confirmed after blanking interval
// - sixteenth battery event latches switch off
// - only supply cycle clears counter and latch
// - overcurrent hiccups off and retries until clear
// - thermal trip holds off until falling limit
// - alarm low while an overvoltage, battery or overcurrent trip is active (not thermal)
// - overcurrent shorter than blanking is ignored
module charge_path_protection_controller
  import charge_guard_pkg::*;
#(
  parameter int STARTUP_CYC = STARTUP_DELAY_CYC,
  parameter int TICK_LEN    = TICK_CYC,
  parameter int RETRY_TICKS = HICCUP_RETRY_US,
  parameter int RAMP_TICKS  = RAMP_STEP_TICKS,
  parameter int BATT_BLANK  = BATT_BLANK_CYC
) (
  // clock and supply-valid reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // comparators and temperature detector
  input  wire sense_t            sense,
  // power switch gate drive
  output logic [GATE_W-1:0]      series_power_switch,
  output logic                   switch_enable,
  // host alarm, open drain
  output logic                   alarm_n_out,
  output logic                   alarm_n_oe,
  // status
  output trip_t                  trips,
  output logic [EVENT_W-1:0]     battery_event_count
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  state_t            state;
  state_t            next_state;
  logic [CNT_W-1:0]  delay_count;
  logic [CNT_W-1:0]  tick_count;
  logic [CNT_W-1:0]  step_count;
  logic [CNT_W-1:0]  retry_count;
  logic              thermal_hold;
  logic              ocur_hold;
  logic              batt_seen;
  logic              batt_ok;
  logic              ocur_ok;
  logic [GATE_W-1:0] next_gate;

  // one-count advance shared by the timebase and interval counters
  function automatic logic [CNT_W-1:0] inc(input logic [CNT_W-1:0] v);
    return v + CNT_W'(1);
  endfunction

  // ----------------------------------------------------------------
  // blanking filters
  // ----------------------------------------------------------------
  blank_filter #(.BLANK_CYC(BATT_BLANK)) u_batt_blank (
    .clk       (clk),
    .resetn    (resetn),
    .level_in  (sense.battery_overvoltage_comparator),
    .confirmed (batt_ok)
  );

  blank_filter #(.BLANK_CYC(OCUR_BLANK_CYC)) u_ocur_blank (
    .clk       (clk),
    .resetn    (resetn),
    .level_in  (sense.overcurrent_comparator),
    .confirmed (ocur_ok)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire ovin       = sense.input_overvoltage_comparator;
  wire tick       = (tick_count == CNT_W'(TICK_LEN - 1));
  wire delay_done = (delay_count == CNT_W'(STARTUP_CYC - 1));
  wire step_due   = tick && (step_count == CNT_W'(RAMP_TICKS - 1));
  wire retry_done = tick && (retry_count == CNT_W'(RETRY_TICKS - 1));
  wire batt_event = batt_ok && !batt_seen;
  wire lock_now   = batt_event && (battery_event_count == EVENT_LAST);
  wire ramp_full  = (series_power_switch == GATE_FULL);
  wire block_on   = ovin || thermal_hold || ocur_hold || batt_ok;
  wire any_alarm  = ovin || batt_ok || ocur_hold;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF:    next_state = ST_DELAY;
      ST_DELAY: begin
        if (ovin) begin
          next_state = ST_DELAY;
        end else if (delay_done && !block_on) begin
          next_state = ST_RAMP;
        end
      end
      ST_RAMP: begin
        if (block_on) begin
          next_state = ST_DELAY;
        end else if (ramp_full) begin
          next_state = ST_ON;
        end
      end
      ST_ON: begin
        if (block_on) begin
          next_state = ST_DELAY;
        end
      end
      ST_LOCKED: next_state = ST_LOCKED;
      default:   next_state = ST_OFF;
    endcase
    if (lock_now) begin
      next_state = ST_LOCKED;
    end
  end

  // drive: immediate cut, one step per ramp interval
  always_comb begin
    next_gate = series_power_switch;
    if (next_state != ST_RAMP && next_state != ST_ON) begin
      next_gate = GATE_OFF;
    end else if (state == ST_RAMP && step_due && !ramp_full) begin
      next_gate = series_power_switch + GATE_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state               <= ST_OFF;
      series_power_switch <= GATE_OFF;
      switch_enable       <= 1'b0;
      battery_event_count <= EVENT_RST;
      batt_seen           <= 1'b0;
    end else begin
      state               <= next_state;
      series_power_switch <= next_gate;
      switch_enable       <= (next_state == ST_RAMP) ||
                             (next_state == ST_ON);
      batt_seen           <= batt_ok;
      if (batt_event && battery_event_count != EVENT_LAST) begin
        battery_event_count <= battery_event_count + EVENT_W'(1);
      end
    end
  end

  // timebase and counters
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tick_count  <= '0;
      delay_count <= '0;
      step_count  <= '0;
    end else begin
      tick_count  <= tick ? '0 : inc(tick_count);
      if (state != ST_DELAY || block_on) begin
        delay_count <= '0;
      end else if (!delay_done) begin
        delay_count <= inc(delay_count);
      end
      if (state != ST_RAMP || step_due) begin
        step_count <= '0;
      end else if (tick) begin
        step_count <= inc(step_count);
      end
    end
  end

  // hiccup and thermal holds
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ocur_hold    <= 1'b0;
      retry_count  <= '0;
      thermal_hold <= 1'b0;
    end else begin
      if (ocur_ok && switch_enable) begin
        ocur_hold   <= 1'b1;
        retry_count <= '0;
      end else if (ocur_hold && retry_done) begin
        ocur_hold   <= 1'b0;
      end else if (ocur_hold && tick) begin
        retry_count <= inc(retry_count);
      end
      if (sense.temp_rising_limit) begin
        thermal_hold <= 1'b1;
      end else if (sense.temp_falling_limit) begin
        thermal_hold <= 1'b0;
      end
    end
  end

  // alarm and status
  always_ff @(posedge clk) begin
    if (!resetn) begin
      alarm_n_out <= 1'b0;
      alarm_n_oe  <= 1'b0;
      trips       <= '0;
    end else begin
      alarm_n_out <= 1'b0;
      alarm_n_oe  <= any_alarm;
      trips       <= '{overvoltage_trip: ovin,
                       battery_trip:     batt_ok,
                       overcurrent_trip: ocur_hold,
                       thermal_trip:     thermal_hold};
    end
  end

endmodule

// [testbench/charge_guard_checker.sv]
// checker: port-level assertions for the charge path controller
`timescale 1ns/1ns
module charge_guard_checker
  import charge_guard_pkg::*;
(
  input wire logic               clk,
  input wire logic               resetn,
  input wire sense_t             sense,
  input wire logic [GATE_W-1:0]  series_power_switch,
  input wire logic               switch_enable,
  input wire logic               alarm_n_out,
  input wire logic               alarm_n_oe,
  input wire trip_t              trips,
  input wire logic [EVENT_W-1:0] battery_event_count
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_startup;
    $rose(resetn) |-> !switch_enable [*8];
  endproperty
  a_startup: assert property (p_startup) else $error("early on");
  property p_ovin;
    sense.input_overvoltage_comparator |=> series_power_switch == GATE_OFF
      && !switch_enable && alarm_n_oe && !alarm_n_out;
  endproperty
  a_ovin: assert property (p_ovin) else $error("ov slow");
  property p_ovblock;
    trips.overvoltage_trip |-> !switch_enable;
  endproperty
  a_ovblock: assert property (p_ovblock) else $error("ov on");
  property p_ramp;
    switch_enable && $past(switch_enable) |-> {1'b0, series_power_switch}
      <= {1'b0, $past(series_power_switch)} + 9'h001;
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp jump");
  property p_bblank;
    $rose(sense.battery_overvoltage_comparator)
      |-> ##2 !trips.battery_trip [*8];
  endproperty
  a_bblank: assert property (p_bblank) else $error("batt blank");
  property p_oblank;
    $rose(sense.overcurrent_comparator) && !trips.overcurrent_trip
      |-> ##2 !trips.overcurrent_trip [*8];
  endproperty
  a_oblank: assert property (p_oblank) else $error("oc blank");
  property p_hiccup;
    $rose(trips.overcurrent_trip) |-> ##[0:2] !switch_enable;
  endproperty
  a_hiccup: assert property (p_hiccup) else $error("oc on");
  property p_thermal;
    sense.temp_rising_limit |-> ##2 series_power_switch == GATE_OFF
      && trips.thermal_trip;
  endproperty
  a_thermal: assert property (p_thermal) else $error("hot on");
  property p_count;
    battery_event_count >= $past(battery_event_count);
  endproperty
  a_count: assert property (p_count) else $error("count drop");
endmodule

// [testbench/charge_guard_frontend.sv]
// partner: comparator front end, shorted load and pulled-up alarm line
`timescale 1ns/1ns
module charge_guard_frontend
  import charge_guard_pkg::*;
(
  // commanded conditions
  input  wire sense_t            cmd,
  input  wire logic              short_load,
  // device side
  input  wire logic [GATE_W-1:0] series_power_switch,
  input  wire logic              alarm_n_out,
  input  wire logic              alarm_n_oe,
  output sense_t                 sense,
  output logic                   alarm_pin
);
  // a shorted load only draws current while the switch conducts
  always_comb begin
    sense = cmd;
    sense.overcurrent_comparator = cmd.overcurrent_comparator |
      (short_load && series_power_switch != GATE_OFF);
  end
  // open-drain line with pull-up, low means the host must act
  assign alarm_pin = alarm_n_oe ? alarm_n_out : 1'b1;
endmodule

// [testbench/charge_path_protection_controller_tb.sv]
// testbench: sequencing and fault scenarios for the charge controller
`timescale 1ns/1ns
module charge_path_protection_controller_tb;
  import charge_guard_pkg::*;
  logic               clk = 1'b0, resetn = 1'b0, short_load = 1'b0;
  logic               switch_enable, alarm_n_out, alarm_n_oe, alarm_pin;
  logic [GATE_W-1:0]  series_power_switch;
  logic [EVENT_W-1:0] battery_event_count;
  sense_t             cmd = '0, sense;
  trip_t              trips;
  logic [17:0]        exp_q[$];
  logic [31:0]        seed = 32'ha78a282a;
  localparam int      BATT_SHORT = 60;
  int                 mismatches = 0, checks = 0;
  wire logic [17:0]   obs = {series_power_switch, switch_enable, alarm_pin,
                             trips, battery_event_count};
  always #5 clk = ~clk;
  charge_path_protection_controller #(.STARTUP_CYC(50), .TICK_LEN(2),
    .RETRY_TICKS(5), .RAMP_TICKS(1), .BATT_BLANK(BATT_SHORT))
    u_charge_path_protection_controller (
    .clk(clk), .resetn(resetn), .sense(sense), .trips(trips),
    .series_power_switch(series_power_switch), .switch_enable(switch_enable),
    .alarm_n_out(alarm_n_out), .alarm_n_oe(alarm_n_oe),
    .battery_event_count(battery_event_count));
  charge_guard_frontend u_charge_guard_frontend (.cmd(cmd), .sense(sense),
    .short_load(short_load), .series_power_switch(series_power_switch),
    .alarm_n_out(alarm_n_out), .alarm_n_oe(alarm_n_oe), .alarm_pin(alarm_pin));
  function automatic int unsigned rnd(input int unsigned m);
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed % m;
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic note(input logic [17:0] e);
    exp_q.push_back(e);
  endtask
  task automatic compare(input logic [17:0] seen, input logic [17:0] want);
    checks++;
    if (seen !== want) begin
      mismatches++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // waits for full drive, or for an overcurrent trip when oc is set
  task automatic wait_on(input bit oc);
    int n;
    n = 0;
    while ((oc ? trips.overcurrent_trip !== 1'b1
               : series_power_switch !== GATE_FULL) && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n == 3000) begin
      mismatches++;
      end_sim();
    end
  endtask
  // oldest note is checked against the settled outputs
  always @(negedge clk) begin
    if (exp_q.size() != 0) compare(obs, exp_q.pop_front());
  end
  initial begin
    step(3);
    resetn <= 1'b1;
    step(45);
    note({8'h00, 1'b0, 1'b1, 4'h0, 4'h0});
    wait_on(0);
    note({GATE_FULL, 1'b1, 1'b1, 4'h0, 4'h0});
    cmd.input_overvoltage_comparator <= 1'b1;
    step(3);
    note({8'h00, 1'b0, 1'b0, 4'h8, 4'h0});
    step(60 + rnd(40));
    note({8'h00, 1'b0, 1'b0, 4'h8, 4'h0});
    cmd.input_overvoltage_comparator <= 1'b0;
    step(20);
    note({8'h00, 1'b0, 1'b1, 4'h0, 4'h0});
    wait_on(0);
    cmd.temp_rising_limit <= 1'b1;
    step(3);
    cmd.temp_rising_limit <= 1'b0;
    step(100);
    note({8'h00, 1'b0, 1'b1, 4'h1, 4'h0});
    cmd.temp_falling_limit <= 1'b1;
    step(3);
    cmd.temp_falling_limit <= 1'b0;
    wait_on(0);
    cmd.overcurrent_comparator <= 1'b1;
    step(10 + rnd(150));
    cmd.overcurrent_comparator <= 1'b0;
    step(5);
    note({GATE_FULL, 1'b1, 1'b1, 4'h0, 4'h0});
    short_load <= 1'b1;
    wait_on(1);
    step(3);
    note({8'h00, 1'b0, 1'b0, 4'h2, 4'h0});
    step(400);
    short_load <= 1'b0;
    wait_on(0);
    for (int i = 1; i <= 16; i++) begin
      cmd.battery_overvoltage_comparator <= 1'b1;
      step(BATT_SHORT - 10);
      note({GATE_FULL, 1'b1, 1'b1, 4'h0, 4'(i - 1)});
      step(20);
      note({8'h00, 1'b0, 1'b0, 4'h4,
            ((i == 16) ? EVENT_LAST : 4'(i))});
      cmd.battery_overvoltage_comparator <= 1'b0;
      if (i < 16) wait_on(0);
    end
    step(100);
    note({8'h00, 1'b0, 1'b1, 4'h0, EVENT_LAST});
    resetn <= 1'b0;
    step(3);
    resetn <= 1'b1;
    step(20);
    note({8'h00, 1'b0, 1'b1, 4'h0, 4'h0});
    wait_on(0);
    note({GATE_FULL, 1'b1, 1'b1, 4'h0, 4'h0});
    step(2);
    end_sim();
  end
endmodule
bind charge_path_protection_controller charge_guard_checker
  u_charge_guard_checker (.clk(clk), .resetn(resetn), .sense(sense),
  .series_power_switch(series_power_switch), .switch_enable(switch_enable),
  .alarm_n_out(alarm_n_out), .alarm_n_oe(alarm_n_oe), .trips(trips),
  .battery_event_count(battery_event_count));
